/* design/ums_uart.sv */
// Serial element core: modem status, divisor, receive and transmit paths, APB slave
// Contract
// - CTS change flag, bit 0, sets when clear-to-send pin changed since read.
// - DSR change flag, bit 1, sets when data-set-ready pin changed since read.
// - Ring flag, bit 2, sets only on ring pin low-to-high.
// - Carrier change flag, bit 3, sets when carrier pin changed since read.
// - Loopback makes status bits 4-7 show modem control bits.
// - Modem status read clears deltas; status bits follow pins outside loopback.
// - Set delta and change during read: change not recorded.
// - Clear delta and change during read: flag set after read.
// - Status setting held off during read; pending set lands at read end.
// - Set bit with recurring condition during read clears at read end.
// - Baud generator divides clock by 1..65535 giving sixteen-times clock.
// - Divisor is 16 bits in low and high byte latches.
// - Writing either divisor latch reloads baud counter at once.
// - Received characters right-justified, bit 0 first, upper bits zero.
// - Receiver samples on sixteen-times clock, aligned to start bit.
// - Completed character loads receive buffer and sets ready flag.
// - Unread character overwritten by next and overrun flag set.
// - Holding register keeps character until shift register is free.
// - Transmitter uses shared word length and stop bits, bit 0 first.
// - Holding-empty flag tracks holding; all-empty needs both registers empty.
// - Scratch byte stores written value, affects nothing else.
// - Status bits 4-7 are inverse of active-low modem pins.
// - Modem interrupt enable with any delta set raises interrupt output.
// - Reading receive buffer clears data-ready flag.
`timescale 1ns/1ps
`default_nettype none
module ums_uart #(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial lines
    input  wire logic        serial_in,
    output logic             serial_out,
    // Modem inputs, active low
    input  wire logic        ctsN,
    input  wire logic        dsrN,
    input  wire logic        ringN,
    input  wire logic        carrierN,
    // Modem outputs, active low
    output logic             dtrN,
    output logic             rtsN,
    output logic             user_output_aN,
    output logic             user_output_bN,
    // Sixteen-times clock tick and interrupt
    output logic             baudTick,
    output logic             irq_out
);
    import ums_pkg::*;

    // Bus decode: zero-wait access, answered in the access phase
    wire        access   = psel && penable;
    wire        wrAcc    = access && pwrite;
    wire        rdAcc    = access && !pwrite;
    wire        mapped   = (paddr <= ADDR_IEN) && (paddr[1:0] == 2'b00);
    wire        wrDivLo  = wrAcc && paddr == ADDR_DIVLO;
    wire        wrDivHi  = wrAcc && paddr == ADDR_DIVHI;
    wire        wrTx     = wrAcc && paddr == ADDR_TXHOLD;
    // Read strobe spans setup and access so a status read masks sets for its whole length
    wire        rdStrobeMs = psel && !pwrite && paddr == ADDR_MDMST;
    wire        rdStrobeLs = psel && !pwrite && paddr == ADDR_LINEST;
    wire        rdEndMs  = rdAcc && paddr == ADDR_MDMST;
    wire        rdEndLs  = rdAcc && paddr == ADDR_LINEST;
    wire        rdRx     = rdAcc && paddr == ADDR_RXBUF;

    logic [7:0] modemCtl, lineCtl, ienReg, scratch_byte, divLo, divHi;
    logic [7:0] receive_buffer, transmit_holding;
    logic [3:0] delta, pend, kill;
    logic [3:0] pinPrev;
    logic       rx_ready_flag, ovrFlag, ovrPend, ovrKill;
    logic       tx_holding_empty_flag, txShiftBusy;

    // Modem control drives outputs; loopback forces them inactive high
    wire        loopOn = modemCtl[MC_LOOP];
    wire [3:0]  pinStat = {~carrierN, ~ringN, ~dsrN, ~ctsN};
    wire [3:0]  loopStat = {modemCtl[MC_OUTB], modemCtl[MC_OUTA], modemCtl[MC_DTR], modemCtl[MC_RTS]};
    wire [3:0]  curStat = loopOn ? loopStat : pinStat;
    // level changes; ring pin rising means status bit falling
    wire [3:0]  chg = {curStat[3] ^ pinPrev[3], pinPrev[2] & ~curStat[2],
                       curStat[1] ^ pinPrev[1], curStat[0] ^ pinPrev[0]};

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pinPrev <= 4'h0;
        end else begin
            pinPrev <= curStat;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            delta <= 4'h0;
            pend  <= 4'h0;
            kill  <= 4'h0;
        end else if (rdStrobeMs && !rdEndMs) begin
            pend <= pend | (chg & ~delta);
            kill <= kill | (chg & delta);
        end else if (rdEndMs) begin
            delta <= (pend | (chg & ~delta)) & ~(kill | (chg & delta));
            pend  <= 4'h0;
            kill  <= 4'h0;
        end else begin
            delta <= delta | chg;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            divLo <= RST_DIVISOR[7:0];
            divHi <= RST_DIVISOR[15:8];
        end else begin
            if (wrDivLo) divLo <= pwdata[7:0];
            if (wrDivHi) divHi <= pwdata[7:0];
        end
    end

    // baud counter, reloaded on any divisor write
    wire [DIV_W-1:0] divisor = {divHi, divLo};
    logic [DIV_W-1:0] baudCnt;
    wire              baudWrap = baudCnt <= DIV_W'(1);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            baudCnt  <= DIV_W'(1);
            baudTick <= 1'b0;
        end else if (wrDivLo || wrDivHi) begin
            baudCnt  <= {wrDivHi ? pwdata[7:0] : divHi, wrDivLo ? pwdata[7:0] : divLo};
            baudTick <= 1'b0;
        end else begin
            baudCnt  <= baudWrap ? divisor : baudCnt - DIV_W'(1);
            baudTick <= baudWrap;
        end
    end

    // Word length 5..8 from line control
    wire [3:0] wordBits = 4'h5 + {2'b00, lineCtl[LC_WLEN_LSB +: 2]};
    wire       twoStop  = lineCtl[LC_STOP];
    function automatic logic [7:0] lenMask(input logic [3:0] n);
        lenMask = 8'hFF >> (4'h8 - n);
    endfunction

    // receiver: loopback takes the shift output
    logic       txLine;
    wire        rxIn = loopOn ? txLine : serial_in;
    ums_state_t rxState;
    logic [3:0] rxPhase, rxCount;
    logic [7:0] rxShift;
    wire        rxSample = baudTick && rxPhase == OVERSAMPLE_MID;
    wire        rxDone   = rxState == UMS_STOP && rxSample;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rxState <= UMS_IDLE;
            rxPhase <= 4'h0;
            rxCount <= 4'h0;
            rxShift <= RST_BYTE;
        end else if (baudTick) begin
            rxPhase <= rxPhase + 4'h1;
            unique case (rxState)
                UMS_IDLE: begin
                    // Start bit position sets the sampling phase
                    rxPhase <= 4'h0;
                    if (!rxIn) rxState <= UMS_DATA;
                    rxCount <= 4'h0;
                end
                UMS_DATA: if (rxSample) begin
                    if (rxCount == 4'h0 && rxIn) begin
                        rxState <= UMS_IDLE;
                    end else if (rxCount != 4'h0) begin
                        rxShift <= {rxIn, rxShift[7:1]};
                    end
                    if (rxCount == wordBits) rxState <= UMS_STOP;
                    rxCount <= rxCount + 4'h1;
                end
                UMS_STOP: if (rxSample) rxState <= UMS_IDLE;
            endcase
        end
    end
    wire [7:0] rxAligned = (rxShift >> (4'h8 - wordBits)) & lenMask(wordBits);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            receive_buffer <= RST_BYTE;
            rx_ready_flag  <= 1'b0;
            ovrFlag        <= 1'b0;
            ovrPend        <= 1'b0;
            ovrKill        <= 1'b0;
        end else begin
            if (rxDone) receive_buffer <= rxAligned;
            rx_ready_flag <= rxDone ? 1'b1 : (rdRx ? 1'b0 : rx_ready_flag);
            // overrun held off during line status read
            if (rdStrobeLs && !rdEndLs) begin
                ovrPend <= ovrPend | (rxDone && rx_ready_flag && !ovrFlag);
                ovrKill <= ovrKill | (rxDone && rx_ready_flag && ovrFlag);
            end else if (rdEndLs) begin
                ovrFlag <= (ovrPend || (rxDone && rx_ready_flag && !ovrFlag)) && !ovrKill;
                ovrPend <= 1'b0;
                ovrKill <= 1'b0;
            end else if (rxDone && rx_ready_flag) begin
                ovrFlag <= 1'b1;
            end
        end
    end

    logic [3:0] txPhase, txCount;
    logic [9:0] txShift;
    wire        txLoad = !txShiftBusy && !tx_holding_empty_flag;
    wire [3:0]  txTotal = wordBits + (twoStop ? 4'h2 : 4'h1);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            transmit_holding      <= RST_BYTE;
            tx_holding_empty_flag <= 1'b1;
            txShiftBusy <= 1'b0;
            txShift     <= 10'h3FF;
            txPhase     <= 4'h0;
            txCount     <= 4'h0;
            txLine      <= 1'b1;
        end else begin
            // Writes while full overwrite the held byte; software must poll the empty flag
            if (wrTx) begin
                transmit_holding      <= pwdata[7:0];
                tx_holding_empty_flag <= 1'b0;
            end else if (txLoad) begin
                tx_holding_empty_flag <= 1'b1;
            end
            if (txLoad) begin
                txShift     <= {2'b11, transmit_holding & lenMask(wordBits)};
                txShiftBusy <= 1'b1;
                txPhase     <= 4'h0;
                txCount     <= 4'h0;
                txLine      <= 1'b0;
            end else if (txShiftBusy && baudTick) begin
                txPhase <= txPhase + 4'h1;
                if (txPhase == OVERSAMPLE_LAST) begin
                    if (txCount == txTotal) begin
                        txShiftBusy <= 1'b0;
                        txLine      <= 1'b1;
                    end else begin
                        txLine  <= txCount < wordBits ? txShift[0] : 1'b1;
                        txShift <= {1'b1, txShift[9:1]};
                    end
                    txCount <= txCount + 4'h1;
                end
            end
        end
    end

    // Register writes for control and scratch; scratch has no side effects
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            modemCtl     <= RST_BYTE;
            lineCtl      <= RST_BYTE;
            ienReg       <= RST_BYTE;
            scratch_byte <= RST_BYTE;
        end else if (wrAcc) begin
            if (paddr == ADDR_MDMCTL)  modemCtl     <= pwdata[7:0] & 8'h1F;
            if (paddr == ADDR_LINECTL) lineCtl      <= pwdata[7:0];
            if (paddr == ADDR_IEN)     ienReg       <= pwdata[7:0] & 8'h0F;
            if (paddr == ADDR_SCRATCH) scratch_byte <= pwdata[7:0];
        end
    end

    // Read mux
    wire [7:0] lineStat = {1'b0, tx_holding_empty_flag && !txShiftBusy, tx_holding_empty_flag,
                           3'b000, ovrFlag, rx_ready_flag};
    wire [7:0] rdByte =
        paddr == ADDR_RXBUF   ? receive_buffer :
        paddr == ADDR_DIVLO   ? divLo :
        paddr == ADDR_DIVHI   ? divHi :
        paddr == ADDR_LINECTL ? lineCtl :
        paddr == ADDR_LINEST  ? lineStat :
        paddr == ADDR_MDMCTL  ? modemCtl :
        paddr == ADDR_MDMST   ? {curStat, delta} :
        paddr == ADDR_SCRATCH ? scratch_byte :
        paddr == ADDR_IEN     ? ienReg : RST_BYTE;

    // Outputs registered; pready high in every access phase
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            serial_out <= 1'b1;
            dtrN <= 1'b1;
            rtsN <= 1'b1;
            user_output_aN <= 1'b1;
            user_output_bN <= 1'b1;
            irq_out <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? {24'h000000, rdByte} : 32'h0000_0000;
            serial_out <= loopOn ? 1'b1 : txLine;
            dtrN <= loopOn || !modemCtl[MC_DTR];
            rtsN <= loopOn || !modemCtl[MC_RTS];
            user_output_aN <= loopOn || !modemCtl[MC_OUTA];
            user_output_bN <= loopOn || !modemCtl[MC_OUTB];
            irq_out <= ienReg[IE_MODEM] && (delta != 4'h0);
        end
    end

    // Assertions
    property p_ctsdelta;
        @(posedge clock) disable iff (!nrst)
        (!psel && chg[0]) |=> delta[0];
    endproperty
    a_ctsdelta: assert property (p_ctsdelta) else $error("cts change flag not set");
    property p_dsrdelta;
        @(posedge clock) disable iff (!nrst)
        (!psel && chg[1]) |=> delta[1];
    endproperty
    a_dsrdelta: assert property (p_dsrdelta) else $error("dsr change flag not set");
    property p_ringfall;
        @(posedge clock) disable iff (!nrst)
        (!psel && !delta[2] && $rose(curStat[2])) |=> !delta[2];
    endproperty
    a_ringfall: assert property (p_ringfall) else $error("ring flag set on wrong edge");
    property p_dcddelta;
        @(posedge clock) disable iff (!nrst)
        (!psel && chg[3]) |=> delta[3];
    endproperty
    a_dcddelta: assert property (p_dcddelta) else $error("carrier change flag not set");
    property p_loopstat;
        @(posedge clock) disable iff (!nrst)
        loopOn |-> curStat[0] == modemCtl[MC_RTS] && curStat[3] == modemCtl[MC_OUTB];
    endproperty
    a_loopstat: assert property (p_loopstat) else $error("loopback status wrong");
    property p_readclr;
        @(posedge clock) disable iff (!nrst)
        (rdEndMs && chg == 4'h0 && pend == 4'h0) |=> delta == 4'h0;
    endproperty
    a_readclr: assert property (p_readclr) else $error("status read did not clear deltas");
    property p_readysets;
        @(posedge clock) disable iff (!nrst)
        rxDone |=> rx_ready_flag && receive_buffer == $past(rxAligned);
    endproperty
    a_readysets: assert property (p_readysets) else $error("ready flag not set");
    property p_overrun;
        @(posedge clock) disable iff (!nrst)
        (rxDone && rx_ready_flag && !rdStrobeLs) |=> ovrFlag;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");
    property p_divreload;
        @(posedge clock) disable iff (!nrst)
        wrDivLo |=> baudCnt[7:0] == $past(pwdata[7:0]);
    endproperty
    a_divreload: assert property (p_divreload) else $error("divisor write did not reload");
    property p_rxclr;
        @(posedge clock) disable iff (!nrst)
        (rdRx && !rxDone) |=> !rx_ready_flag;
    endproperty
    a_rxclr: assert property (p_rxclr) else $error("ready flag not cleared");
    c_rxchar: cover property (@(posedge clock) disable iff (!nrst) rxDone);
    c_txload: cover property (@(posedge clock) disable iff (!nrst) txLoad);
    c_msrrace: cover property (@(posedge clock) disable iff (!nrst) rdStrobeMs && chg != 4'h0);
endmodule
`default_nettype wire

/* design/ums_pkg.sv */
// Package for the serial element: register map, field positions, reset values
package ums_pkg;
    // Register byte addresses (one 32-bit word each)
    localparam logic [7:0] ADDR_RXBUF   = 8'h00;
    localparam logic [7:0] ADDR_TXHOLD  = 8'h04;
    localparam logic [7:0] ADDR_DIVLO   = 8'h08;
    localparam logic [7:0] ADDR_DIVHI   = 8'h0C;
    localparam logic [7:0] ADDR_LINECTL = 8'h10;
    localparam logic [7:0] ADDR_LINEST  = 8'h14;
    localparam logic [7:0] ADDR_MDMCTL  = 8'h18;
    localparam logic [7:0] ADDR_MDMST   = 8'h1C;
    localparam logic [7:0] ADDR_SCRATCH = 8'h20;
    localparam logic [7:0] ADDR_IEN     = 8'h24;
    // Modem control fields
    localparam int MC_DTR  = 0;
    localparam int MC_RTS  = 1;
    localparam int MC_OUTA = 2;
    localparam int MC_OUTB = 3;
    localparam int MC_LOOP = 4;
    // Line control fields: word length code and stop bits
    localparam int LC_WLEN_LSB = 0;
    localparam int LC_STOP     = 2;
    // Line status fields
    localparam int LS_READY = 0;
    localparam int LS_OVRUN = 1;
    localparam int LS_THE   = 5;
    localparam int LS_TX_ALL_EMPTY_FLAG  = 6;
    // Interrupt enable field for modem status
    localparam int IE_MODEM = 3;
    // Reset values
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [15:0] RST_DIVISOR = 16'h0001;
    // Oversampling ratio of the baud clock
    localparam logic [3:0]  OVERSAMPLE_LAST = 4'hF;
    localparam logic [3:0]  OVERSAMPLE_MID  = 4'h7;
    typedef enum logic [2:0] {
        UMS_IDLE  = 3'b001,
        UMS_DATA  = 3'b010,
        UMS_STOP  = 3'b100
    } ums_state_t;
endpackage

/* bench/ums_modem.sv */
// Modem side model: handshake pin levels and serial character source
`timescale 1ns/1ps
`default_nettype none
module ums_modem #(
    parameter int BIT_CYCLES = 16
) (
    // Clock and pin toggle request
    input  wire logic       clock,
    input  wire logic [3:0] flip,
    // Lines toward the element, modem pins active low
    output logic            serial_in,
    output wire logic       ctsN,
    output wire logic       dsrN,
    output wire logic       ringN,
    output wire logic       carrierN
);
    logic [3:0] levels;
    // Pins start inactive; a toggle lands one edge after it is asked for
    initial levels = 4'hF;
    always @(posedge clock)
        levels <= levels ^ flip;
    assign {carrierN, ringN, dsrN, ctsN} = levels;
    initial serial_in = 1'b1;
    // start bit, bit 0 first, one stop bit
    task automatic send_char(input logic [7:0] value, input int nbits);
        @(posedge clock);
        serial_in <= 1'b0;
        repeat (BIT_CYCLES) @(posedge clock);
        for (int i = 0; i < nbits; i++) begin
            serial_in <= value[i];
            repeat (BIT_CYCLES) @(posedge clock);
        end
        serial_in <= 1'b1;
        repeat (BIT_CYCLES) @(posedge clock);
    endtask
endmodule
`default_nettype wire

/* bench/uart_modem_status_baud_buffers_bench.sv */
// Self-checking bench for the serial element
`timescale 1ns/1ps
`default_nettype none
module uart_modem_status_baud_buffers_bench;
    import ums_pkg::*;
    logic        clock, nrst, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0]  paddr, got0, got1;
    logic [31:0] pwdata, prdata, rdata;
    logic        serial_in, serial_out, ctsN, dsrN, ringN, carrierN, baudTick, irq_out;
    logic        dtrN, rtsN, user_output_aN, user_output_bN;
    logic [3:0]  flip;
    int          fail_count, compares;

    ums_uart dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_in(serial_in), .serial_out(serial_out), .ctsN(ctsN), .dsrN(dsrN), .ringN(ringN),
        .carrierN(carrierN), .dtrN(dtrN), .rtsN(rtsN), .user_output_aN(user_output_aN),
        .user_output_bN(user_output_bN), .baudTick(baudTick), .irq_out(irq_out));
    ums_modem #(.BIT_CYCLES(16)) modem (.clock(clock), .flip(flip), .serial_in(serial_in),
        .ctsN(ctsN), .dsrN(dsrN), .ringN(ringN), .carrierN(carrierN));

    always #5 clock = ~clock;

    task automatic test_done;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        compares++;
        if (seen !== expected) begin
            fail_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, expected);
        end
    endtask
    task automatic timeout;
        fail_count++;
        $display("ERROR %0t wait ran out", $time);
        test_done();
    endtask
    // Pin toggles ride on the setup cycle so they land inside a read
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] data, input logic [3:0] tog);
        int n;
        @(posedge clock);
        {psel, penable, pwrite, paddr, pwdata, flip} <= {1'b1, 1'b0, wr, addr, 24'h000000, data, tog};
        @(posedge clock);
        penable <= 1'b1;
        flip <= 4'h0;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
            timeout();
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        apb(1'b1, addr, data, 4'h0);
    endtask
    task automatic rd(input logic [7:0] addr);
        apb(1'b0, addr, 8'h00, 4'h0);
    endtask
    task automatic pulse(input logic [3:0] mask);
        @(posedge clock);
        flip <= mask;
        @(posedge clock);
        flip <= 4'h0;
    endtask
    task automatic send(input logic [7:0] value, input int nbits);
        modem.send_char(value, nbits);
        repeat (4) @(posedge clock);
    endtask
    task automatic tick_gap(output int first, output int gap);
        first = 0;
        gap = 0;
        do begin
            @(posedge clock);
            first++;
        end while (baudTick !== 1'b1 && first < 600);
        if (baudTick !== 1'b1)
            timeout();
        do begin
            @(posedge clock);
            gap++;
        end while (baudTick !== 1'b1 && gap < 600);
        if (baudTick !== 1'b1)
            timeout();
    endtask
    task automatic capture(output logic [7:0] value);
        int n;
        n = 0;
        while (serial_out !== 1'b0 && n < 400) begin
            @(posedge clock);
            n++;
        end
        if (n == 400)
            timeout();
        repeat (8) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            repeat (16) @(posedge clock);
            value[i] = serial_out;
        end
        repeat (16) @(posedge clock);
        check(32'(serial_out), 32'h1);
    endtask

    task automatic t_regs;
        int first;
        int gap;
        rd(ADDR_DIVLO);
        check(rdata, 32'h1);
        rd(8'h28);
        check(32'({rerr, rdata[7:0]}), 32'h100);
        wr(ADDR_SCRATCH, 8'h5A);
        wr(ADDR_DIVLO, 8'h03);
        wr(ADDR_DIVHI, 8'h01);
        rd(ADDR_DIVHI);
        check(rdata, 32'h1);
        tick_gap(first, gap);
        check(32'(gap), 32'd259);
        wr(ADDR_DIVHI, 8'h00);
        tick_gap(first, gap);
        check(32'(first <= 6), 32'h1);
        check(32'(gap), 32'd3);
        wr(ADDR_DIVLO, 8'h01);
        rd(ADDR_SCRATCH);
        check(rdata, 32'h5A);
    endtask
    task automatic t_modem;
        wr(ADDR_IEN, 8'h08);
        rd(ADDR_MDMST);
        check(rdata, 32'h00);
        pulse(4'hF);
        repeat (3) @(posedge clock);
        check(32'(irq_out), 32'h1);
        rd(ADDR_MDMST);
        check(rdata, 32'hFB);
        rd(ADDR_MDMST);
        check(rdata, 32'hF0);
        repeat (2) @(posedge clock);
        check(32'(irq_out), 32'h0);
        pulse(4'h4);
        rd(ADDR_MDMST);
        check(rdata, 32'hB4);
        apb(1'b0, ADDR_MDMST, 8'h00, 4'h1);
        rd(ADDR_MDMST);
        check(rdata, 32'hA1);
        pulse(4'h1);
        apb(1'b0, ADDR_MDMST, 8'h00, 4'h1);
        rd(ADDR_MDMST);
        check(rdata, 32'hA0);
        wr(ADDR_MDMCTL, 8'h12);
        rd(ADDR_MDMST);
        check(32'(rdata[7:4]), 32'h1);
        check(32'({dtrN, rtsN, user_output_aN, user_output_bN, serial_out}), 32'h1F);
        wr(ADDR_MDMCTL, 8'h0F);
        repeat (2) @(posedge clock);
        check(32'({dtrN, rtsN, user_output_aN, user_output_bN}), 32'h0);
        wr(ADDR_MDMCTL, 8'h00);
    endtask
    task automatic t_rx;
        wr(ADDR_LINECTL, 8'h03);
        send(8'hA5, 8);
        rd(ADDR_LINEST);
        check(32'(rdata[1:0]), 32'h1);
        rd(ADDR_RXBUF);
        check(rdata, 32'hA5);
        rd(ADDR_LINEST);
        check(32'(rdata[0]), 32'h0);
        wr(ADDR_LINECTL, 8'h00);
        send(8'hF5, 5);
        rd(ADDR_RXBUF);
        check(rdata, 32'h15);
        wr(ADDR_LINECTL, 8'h03);
        send(8'h3C, 8);
        send(8'hC3, 8);
        rd(ADDR_LINEST);
        check(32'(rdata[1:0]), 32'h3);
        rd(ADDR_RXBUF);
        check(rdata, 32'hC3);
    endtask
    task automatic t_tx;
        fork
            begin
                capture(got0);
                capture(got1);
            end
            begin
                wr(ADDR_TXHOLD, 8'h96);
                wr(ADDR_TXHOLD, 8'h5A);
                rd(ADDR_LINEST);
                check(32'(rdata[6:5]), 32'h0);
            end
        join
        check(32'(got0), 32'h96);
        check(32'(got1), 32'h5A);
        repeat (40) @(posedge clock);
        rd(ADDR_LINEST);
        check(32'(rdata[6:5]), 32'h3);
        // Two stop bits keep the shifter busy one bit longer than one stop bit would
        wr(ADDR_LINECTL, 8'h07);
        wr(ADDR_TXHOLD, 8'hFF);
        repeat (160) @(posedge clock);
        rd(ADDR_LINEST);
        check(32'(rdata[6]), 32'h0);
        repeat (20) @(posedge clock);
        rd(ADDR_LINEST);
        check(32'(rdata[6]), 32'h1);
    endtask

    initial begin
        {clock, nrst, psel, penable, pwrite, paddr, pwdata, flip} = '0;
        fail_count = 0;
        compares = 0;
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        t_regs();
        t_modem();
        t_rx();
        t_tx();
        test_done();
    end
endmodule
`default_nettype wire
